// >>> inc/aprc_pkg.sv
// Package for the ADC port and reference configuration block
package aprc_pkg;

	// Register map (word offsets are byte addresses)
	localparam logic [7:0] ADDR_PORT_REF_CFG = 8'h00;
	localparam int         ADDR_W            = 8;

	// Field positions
	localparam int NEG_REF_BIT  = 5;
	localparam int POS_REF_BIT  = 4;
	localparam int PCFG_LSB     = 0;
	localparam int PCFG_W       = 4;

	// Reset values
	localparam logic [3:0] PCFG_RST_ANALOG  = 4'h0;
	localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
	localparam logic       REF_SEL_RST      = 1'b0;

	// Decode limits
	localparam int         NUM_INPUTS       = 13;
	localparam logic [3:0] PCFG_ALL_ANALOG  = 4'h2;

	// Stored configuration
	typedef struct packed {
		logic       neg_ref_select;
		logic       pos_ref_select;
		logic [3:0] port_config_field;
	} aprc_cfg_s;

	// Reference routing outputs
	typedef struct packed {
		logic neg_ref_ext;
		logic pos_ref_ext;
	} aprc_ref_s;

endpackage

// >>> rtl/aprc_top.sv
// ADC port and reference configuration register with Wishbone slave
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module aprc_top #(
	parameter int         NUM_IN    = aprc_pkg::NUM_INPUTS,
	parameter bit         LARGE_PKG = 1'b1
) (
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST,
	// Nonvolatile configuration
	input  wire logic              POR_ANALOG_DEFAULT_FUSE,
	// Wishbone slave
	input  wire logic              WB_CYC_I,
	input  wire logic              WB_STB_I,
	input  wire logic              WB_WE_I,
	input  wire logic [7:0]        WB_ADR_I,
	input  wire logic [3:0]        WB_SEL_I,
	input  wire logic [31:0]       WB_DAT_I,
	output logic      [31:0]       WB_DAT_O,
	output logic                   WB_ACK_O,
	output logic                   WB_ERR_O,
	// Converter controls
	output aprc_pkg::aprc_ref_s    REF_SEL,
	output logic      [NUM_IN-1:0] ANALOG_SELECT
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic [NUM_IN-1:0] decode_pcfg(input logic [3:0] code);
		logic [NUM_IN-1:0] v;
		int                n_dig;
		v     = '1;
		n_dig = 0;
		if (code > aprc_pkg::PCFG_ALL_ANALOG) begin
			n_dig = int'(code) - int'(aprc_pkg::PCFG_ALL_ANALOG);
		end
		for (int i = 0; i < NUM_IN; i++) begin
			if (i >= NUM_IN - n_dig) begin
				v[i] = 1'b0;
			end
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Fuse synchroniser; strap caught after reset release

	logic               fuse_s1_q;
	logic               fuse_s2_q;
	logic               por_done_q;
	aprc_pkg::aprc_cfg_s cfg_q;
	aprc_pkg::aprc_cfg_s cfg_d;
	logic               ack_q;
	logic               ack_d;
	logic               err_q;
	logic               err_d;
	logic [31:0]        rdat_q;
	logic [31:0]        rdat_d;
	logic               req;
	logic               hit;

	always_ff @(posedge CLK_SYS) begin
		fuse_s1_q <= POR_ANALOG_DEFAULT_FUSE;
		fuse_s2_q <= fuse_s1_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register and bus logic

	assign req = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
	assign hit = (WB_ADR_I == aprc_pkg::ADDR_PORT_REF_CFG);

	always_comb begin
		cfg_d  = cfg_q;
		ack_d  = 1'b0;
		err_d  = 1'b0;
		rdat_d = rdat_q;
		if (!por_done_q) begin
			// Fuse reaches the synchroniser output two edges after it changes; the synchroniser is not reset
			cfg_d.port_config_field = fuse_s2_q ? aprc_pkg::PCFG_RST_ANALOG
			                                    : aprc_pkg::PCFG_RST_DIGITAL;
		end else if (req && hit) begin
			ack_d = 1'b1;
			if (WB_WE_I && WB_SEL_I[0]) begin
				cfg_d.neg_ref_select    = WB_DAT_I[aprc_pkg::NEG_REF_BIT];
				cfg_d.pos_ref_select    = WB_DAT_I[aprc_pkg::POS_REF_BIT];
				cfg_d.port_config_field = WB_DAT_I[aprc_pkg::PCFG_LSB +: aprc_pkg::PCFG_W];
			end
			rdat_d = '0;
			rdat_d[aprc_pkg::NEG_REF_BIT] = cfg_q.neg_ref_select;
			rdat_d[aprc_pkg::POS_REF_BIT] = cfg_q.pos_ref_select;
			rdat_d[aprc_pkg::PCFG_LSB +: aprc_pkg::PCFG_W] = cfg_q.port_config_field;
		end else if (req) begin
			err_d  = 1'b1;
			rdat_d = '0;
		end
	end

	// Counter of four edges lets the fuse synchroniser settle before sampling
	logic [1:0] por_cnt_q;
	logic [1:0] por_cnt_d;
	logic       por_done_d;

	always_comb begin
		por_cnt_d  = por_cnt_q;
		por_done_d = por_done_q;
		if (por_cnt_q != 2'h3) begin
			por_cnt_d = por_cnt_q + 2'h1;
		end else begin
			por_done_d = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cfg_q.neg_ref_select    <= aprc_pkg::REF_SEL_RST;
			cfg_q.pos_ref_select    <= aprc_pkg::REF_SEL_RST;
			cfg_q.port_config_field <= aprc_pkg::PCFG_RST_DIGITAL;
			ack_q                   <= 1'b0;
			err_q                   <= 1'b0;
			rdat_q                  <= '0;
			por_cnt_q               <= 2'h0;
			por_done_q              <= 1'b0;
		end else begin
			cfg_q      <= cfg_d;
			ack_q      <= ack_d;
			err_q      <= err_d;
			rdat_q     <= rdat_d;
			por_cnt_q  <= por_cnt_d;
			por_done_q <= por_done_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_ERR_O = err_q;
	assign WB_DAT_O = rdat_q;

	////////////////////////////////////////////////////////////////////////////
	// Converter-facing outputs

	logic [NUM_IN-1:0] dec;

	// One driver for the whole struct; split member assigns trip some tools
	always_comb begin
		REF_SEL.neg_ref_ext = cfg_q.neg_ref_select;
		REF_SEL.pos_ref_ext = cfg_q.pos_ref_select;
	end
	assign dec = decode_pcfg(cfg_q.port_config_field);

	// Small package: inputs 5..7 have no pin, so they read as digital
	always_comb begin
		ANALOG_SELECT = dec;
		if (!LARGE_PKG) begin
			for (int i = 5; i <= 7; i++) begin
				ANALOG_SELECT[i] = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_rsvd_zero;
		@(posedge CLK_SYS) disable iff (RST) WB_ACK_O |-> WB_DAT_O[7:6] == 2'b00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits read nonzero");

	property p_neg_ref;
		@(posedge CLK_SYS) disable iff (RST)
			(req && hit && WB_WE_I && WB_SEL_I[0] && por_done_q)
			|=> REF_SEL.neg_ref_ext == $past(WB_DAT_I[aprc_pkg::NEG_REF_BIT]);
	endproperty
	a_neg_ref: assert property (p_neg_ref) else $error("Negative reference select not written");

	property p_pos_ref;
		@(posedge CLK_SYS) disable iff (RST)
			(req && hit && WB_WE_I && WB_SEL_I[0] && por_done_q)
			|=> REF_SEL.pos_ref_ext == $past(WB_DAT_I[aprc_pkg::POS_REF_BIT]);
	endproperty
	a_pos_ref: assert property (p_pos_ref) else $error("Positive reference select not written");

	property p_all_digital;
		@(posedge CLK_SYS) disable iff (RST) cfg_q.port_config_field == 4'hF |-> ANALOG_SELECT == '0;
	endproperty
	a_all_digital: assert property (p_all_digital) else $error("Code 1111 left an analog input");

	property p_low_analog;
		@(posedge CLK_SYS) disable iff (RST)
			(cfg_q.port_config_field <= aprc_pkg::PCFG_ALL_ANALOG && LARGE_PKG) |-> &ANALOG_SELECT;
	endproperty
	a_low_analog: assert property (p_low_analog) else $error("Low code left a digital input");

	property p_top_first;
		@(posedge CLK_SYS) disable iff (RST)
			cfg_q.port_config_field == 4'h3 |-> !ANALOG_SELECT[NUM_IN-1] && ANALOG_SELECT[NUM_IN-2];
	endproperty
	a_top_first: assert property (p_top_first) else $error("Code 0011 decode wrong");

	property p_por_load;
		@(posedge CLK_SYS) disable iff (RST)
			$rose(por_done_q) |-> cfg_q.port_config_field == (fuse_s2_q ? aprc_pkg::PCFG_RST_ANALOG
			                                                            : aprc_pkg::PCFG_RST_DIGITAL);
	endproperty
	a_por_load: assert property (p_por_load) else $error("Power-on port code wrong");

	property p_small_pkg;
		@(posedge CLK_SYS) disable iff (RST) !LARGE_PKG |-> ANALOG_SELECT[7:5] == 3'b000;
	endproperty
	a_small_pkg: assert property (p_small_pkg) else $error("Absent inputs marked analog");

	property p_ref_reset;
		@(posedge CLK_SYS) $fell(RST) |-> (REF_SEL == 2'h0) [*2];
	endproperty
	a_ref_reset: assert property (p_ref_reset) else $error("Reference selects not zero after reset");

endmodule

`default_nettype wire

// >>> verif/aprc_top_bench.sv
// Self-checking bench for the port and reference config block
`timescale 1ns/10ps
`default_nettype none

module aprc_top_bench;
	logic                clk;
	logic                rst;
	logic                fuse;
	logic                cyc;
	logic                stb;
	logic                we;
	logic [7:0]          adr;
	logic [3:0]          sel;
	logic [31:0]         wd;
	logic [31:0]         rdo;
	logic                ack;
	logic                err;
	aprc_pkg::aprc_ref_s rsel;
	logic [12:0]         an;
	logic [12:0]         an_s;
	int                  bad_count;
	int                  checks_done;
	int                  cycles;
	logic [31:0]         rd;
	logic                rerr;
	logic [5:0]          cur;
	logic [31:0]         v;
	logic [7:0]          a;
	logic [3:0]          s;
	logic                ok;

	aprc_top DUT (
		.CLK_SYS(clk), .RST(rst), .POR_ANALOG_DEFAULT_FUSE(fuse),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdo), .WB_ACK_O(ack),
		.WB_ERR_O(err), .REF_SEL(rsel), .ANALOG_SELECT(an)
	);

	// Small package variant on the same bus; only its input vector is watched
	aprc_top #(.LARGE_PKG(1'b0)) DUT_SMALL (
		.CLK_SYS(clk), .RST(rst), .POR_ANALOG_DEFAULT_FUSE(fuse),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(), .WB_ACK_O(),
		.WB_ERR_O(), .REF_SEL(), .ANALOG_SELECT(an_s)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Highest inputs go digital first
	function automatic logic [12:0] exp_an(input logic [3:0] c);
		return (c <= 4'h2) ? 13'h1FFF : 13'h1FFF >> (c - 4'h2);
	endfunction

	// Classic cycle; held until answered
	task automatic bus(input logic w, input logic [7:0] ad, input logic [3:0] sl, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		sel <= sl;
		wd <= d;
		@(posedge clk iff (ack | err));
		rd = rdo;
		rerr = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic do_reset(input logic f);
		rst <= 1'b1;
		fuse <= f;
		repeat (20) @(posedge clk);
		cmp("an in reset", 32'h0000_00FF, {19'h0, an});
		cmp("ref in reset", 32'h0, {30'h0, rsel});
		cmp("an small in reset", 32'h0000_001F, {19'h0, an_s});
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		bus(1'b0, 8'h00, 4'hF, 32'h0);
		cur = f ? 6'h00 : 6'h07;
		cmp("por code", {26'h0, cur}, rd);
		cmp("por an", {19'h0, exp_an(cur[3:0])}, {19'h0, an});
		cmp("por an small", {19'h0, exp_an(cur[3:0]) & 13'h1F1F}, {19'h0, an_s});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Tests need well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		{fuse, cyc, stb, we, adr, sel, wd} = '0;
		rst = 1'b1; // Held from time zero; no edge sees an unreset design
		{bad_count, checks_done, cycles} = '0;
		void'($urandom(32'h0171));
		@(posedge clk);
		do_reset(1'b1);
		for (int i = 0; i < 48; i++) begin
			v = $urandom();
			if (i < 16) begin
				v[3:0] = i[3:0];
			end
			a = (i >= 16 && i % 7 == 6) ? (v[15:8] | 8'h01) : 8'h00;
			s = (i >= 16 && i % 5 == 4) ? 4'hE : 4'hF;
			ok = (a == 8'h00);
			bus(1'b1, a, s, v);
			cmp("err", {31'h0, !ok}, {31'h0, rerr});
			if (ok && s[0]) begin
				cur = v[5:0];
			end
			bus(1'b0, 8'h00, 4'hF, 32'h0);
			cmp("readback", {26'h0, cur}, rd);
			cmp("analog", {19'h0, exp_an(cur[3:0])}, {19'h0, an});
			cmp("ref", {30'h0, cur[5:4]}, {30'h0, rsel});
			cmp("analog small", {19'h0, exp_an(cur[3:0]) & 13'h1F1F}, {19'h0, an_s});
		end
		// Both selects set so the mid-run reset must really clear them
		bus(1'b1, 8'h00, 4'hF, 32'h0000_003F);
		cmp("ref set", 32'h0000_0003, {30'h0, rsel});
		do_reset(1'b0);
		conclude();
	end
endmodule
`default_nettype wire
